//--- mmhi_pkg.sv
// Shared constants and types of the multi-mode host interface
package mmhi_pkg;
  // Strap codes, ordered {strap_zero, strap_one, strap_two}
  localparam logic [2:0] MMHI_MODE_6800 = 3'h1;
  localparam logic [2:0] MMHI_MODE_8080 = 3'h3;
  localparam logic [2:0] MMHI_MODE_SPI4 = 3'h0;
  localparam logic [2:0] MMHI_MODE_SPI3 = 3'h4;
  localparam logic [2:0] MMHI_MODE_I2C = 3'h2;
  // Upper six bits of the 7-bit slave address
  localparam logic [5:0] MMHI_I2C_ADDR_HI = 6'h1E;
  // Bit counts at which a serial byte completes
  localparam logic [3:0] MMHI_SPI4_LAST = 4'h7;
  localparam logic [3:0] MMHI_SPI3_LAST = 4'h8;
  localparam logic [3:0] MMHI_I2C_BITS = 4'h8;
  // Number of synchronised pin bits
  localparam int MMHI_SYNC_W = 16;
  // Reset values
  localparam logic [7:0] MMHI_BYTE_RST = 8'h00;
  localparam logic [3:0] MMHI_CNT_RST = 4'h0;
  // Byte phases of an I2C write
  localparam logic [1:0] MMHI_PH_ADDR = 2'h0;
  localparam logic [1:0] MMHI_PH_CTRL = 2'h1;
  localparam logic [1:0] MMHI_PH_DATA = 2'h2;
  // I2C slave states
  typedef enum logic [4:0] {
    MMHI_I_IDLE = 5'h01,
    MMHI_I_RX = 5'h02,
    MMHI_I_ACK = 5'h04,
    MMHI_I_TX = 5'h08,
    MMHI_I_MACK = 5'h10
  } mmhi_i2c_st_t;
endpackage

//--- mmhi_sync.sv
// Two-flop synchronisers for every pin input
`timescale 1ns/1ps
`default_nettype none
module mmhi_sync
  import mmhi_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [MMHI_SYNC_W-1:0] i_pins,
  output logic [MMHI_SYNC_W-1:0] o_pins
);
  logic [MMHI_SYNC_W-1:0] meta_r; // First stage, read only by the second

  // One pair of flops per pin bit
  genvar g;
  generate
    for (g = 0; g < MMHI_SYNC_W; g++)
    begin : g_bit
      always_ff @(posedge i_sys_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          meta_r[g] <= 1'b1;
          o_pins[g] <= 1'b1;
        end
        else
        begin
          meta_r[g] <= i_pins[g];
          o_pins[g] <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- mmhi_spi_rx.sv
// Serial receiver shared by 4-wire and 3-wire SPI
`timescale 1ns/1ps
`default_nettype none
module mmhi_spi_rx
  import mmhi_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic i_three_wire,
  input wire logic i_cs_n,
  input wire logic i_scl_rise,
  input wire logic i_si,
  input wire logic i_dc,
  output logic o_valid,
  output logic [7:0] o_byte,
  output logic o_is_data
);
  logic [8:0] shift_r; // Holds flag and data bits, MSB first
  logic [3:0] cnt_r; // Bits taken in this frame
  logic [3:0] last; // Count of the closing bit

  assign last = i_three_wire ? MMHI_SPI3_LAST : MMHI_SPI4_LAST;

  // Shifting and byte hand-off
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      shift_r <= 9'h000;
      cnt_r <= MMHI_CNT_RST;
      o_valid <= 1'b0;
      o_byte <= MMHI_BYTE_RST;
      o_is_data <= 1'b0;
    end
    else
    begin
      o_valid <= 1'b0;
      if (!i_en || i_cs_n)
      begin
        // Deselected: back to the initial state, clock ignored
        shift_r <= 9'h000; // see RULE11 see RULE13
        cnt_r <= MMHI_CNT_RST;
      end
      else if (i_scl_rise)
      begin
        shift_r <= {shift_r[7:0], i_si}; // see RULE9 see RULE15
        if (cnt_r == last)
        begin
          cnt_r <= MMHI_CNT_RST;
          o_valid <= 1'b1;
          o_byte <= {shift_r[6:0], i_si};
          // Leading flag in 3-wire, select pin on the eighth edge in 4-wire
          o_is_data <= i_three_wire ? shift_r[7] : i_dc; // see RULE10 see RULE16
        end
        else
        begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end

  AST_SPI_DESEL_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see RULE13
    (i_en && i_cs_n) |=> (cnt_r == MMHI_CNT_RST && !o_valid))
    else $error("serial counter not cleared while deselected");
  AST_SPI4_EIGHTH: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see RULE10
    (i_en && !i_three_wire && !i_cs_n && i_scl_rise && cnt_r == MMHI_SPI4_LAST)
    |=> (o_valid && o_is_data == $past(i_dc)))
    else $error("4-wire byte not delivered on eighth edge");
  AST_SPI3_NINTH: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see RULE15
    (i_en && i_three_wire && !i_cs_n && i_scl_rise && cnt_r != MMHI_SPI3_LAST) |=> !o_valid)
    else $error("3-wire byte delivered before ninth edge");
endmodule
`default_nettype wire

//--- mmhi_top.sv
// Multi-mode host port: 6800, 8080, 4/3-wire SPI and I2C slave
// Contract
// RULE1: straps pick one of five host buses
// RULE2: 6800 R/W high reads, low writes
// RULE3: 6800 E high latches, only with CS low
// RULE4: dummy read first; RAM data lags one
// RULE5: 8080 RD low reads; select picks status/data
// RULE6: 8080 WR low writes; select picks RAM/command
// RULE7: host issues dummy read in 8080 too
// RULE8: select and direction decode the four accesses
// RULE9: 4-wire shifts eight bits MSB first
// RULE10: eighth edge samples select and delivers byte
// RULE11: CS high holds serial port idle
// RULE12: CS falling starts a serial transfer
// RULE13: deselect clears shift register and counter
// RULE14: no read path in SPI modes
// RULE15: 3-wire shifts nine bits, flag first
// RULE16: 3-wire flag routes byte RAM or command
// RULE17: I2C slave only; writes and reads
// RULE18: SDA change with SCL high is control
// RULE19: START and STOP from SDA with SCL high
// RULE20: slave acks each received byte low
// RULE21: master nack on read: release SDA
// RULE22: address 011110 plus strap LSB
// RULE23: control byte carries chain and D/C flags
// RULE24: I2C read data follows last D/C
// RULE25: straps static, unselected inputs ignored
`timescale 1ns/1ps
`default_nettype none
module mmhi_top
  import mmhi_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_interface_strap_zero,
  input wire logic i_interface_strap_one,
  input wire logic i_interface_strap_two,
  input wire logic i_address_lsb_strap,
  input wire logic i_cs_n,
  input wire logic i_data_command_select,
  input wire logic i_rd_e,
  input wire logic i_wr_rw,
  input wire logic [7:0] i_data,
  input wire logic [7:0] i_status,
  input wire logic [7:0] i_ram_rdata,
  output logic [7:0] o_data,
  output logic [7:0] o_data_oe_n,
  output logic o_wr_valid,
  output logic o_wr_is_data,
  output logic [7:0] o_wr_byte,
  output logic o_ram_rd
);
  logic [MMHI_SYNC_W-1:0] pin_s; // Synchronised pins
  logic [7:0] d_s; // Data pins; D0 is SCL, D1 is SI or SDA
  logic wr_s, rd_s, dc_s, cs_n_s, sa0_s;
  logic [2:0] mode; // Strap code
  logic scl_d_r, sda_d_r; // Delayed copies for edge detection
  logic scl_rise, scl_fall, i2c_start, i2c_stop;
  logic m6800, m8080, m_par, m_spi, m_i2c;
  logic strobe_rd, strobe_wr; // Parallel strobe levels
  logic rd_act_r, wr_act_r; // Strobe levels one cycle back
  logic [7:0] wr_data_r; // Byte latched during a write strobe
  logic wr_dc_r, rd_dc_r;
  logic [7:0] ram_pipe_r; // Read pipeline stage, source of the dummy read
  logic spi_v, spi_dc;
  logic [7:0] spi_byte;
  mmhi_i2c_st_t i2c_st_r;
  logic [7:0] i2c_sh_r; // I2C shift register, both directions
  logic [3:0] i2c_cnt_r;
  logic [1:0] i2c_ph_r; // Address, control or data byte next
  logic i2c_rw_r, chain_r, dc_last_r, nack_r, sda_rel_r;
  logic i2c_wr_v_r, i2c_rd_r;
  logic [7:0] tx_byte;

  mmhi_sync u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pins({i_data, i_wr_rw, i_rd_e, i_data_command_select, i_cs_n, i_address_lsb_strap,
      i_interface_strap_zero, i_interface_strap_one, i_interface_strap_two}),
    .o_pins(pin_s)
  );
  assign {d_s, wr_s, rd_s, dc_s, cs_n_s, sa0_s, mode} = pin_s;

  // Mode decode; straps are assumed not to move in operation
  assign m6800 = (mode == MMHI_MODE_6800); // see RULE1 see RULE25
  assign m8080 = (mode == MMHI_MODE_8080);
  assign m_par = m6800 || m8080;
  assign m_spi = (mode == MMHI_MODE_SPI4) || (mode == MMHI_MODE_SPI3);
  assign m_i2c = (mode == MMHI_MODE_I2C);

  // Serial line edges, taken from the second flop only
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_d_r <= d_s[0];
      sda_d_r <= d_s[1];
    end
  end
  assign scl_rise = d_s[0] && !scl_d_r;
  assign scl_fall = !d_s[0] && scl_d_r;
  // Data moving with clock high is a condition, never a bit
  assign i2c_start = d_s[0] && scl_d_r && sda_d_r && !d_s[1]; // see RULE18 see RULE19
  assign i2c_stop = d_s[0] && scl_d_r && !sda_d_r && d_s[1]; // see RULE19

  // Strobes: 6800 E high with R/W, 8080 active-low RD and WR, all gated by CS
  assign strobe_rd = !cs_n_s && (m6800 ? (rd_s && wr_s) : (m8080 && !rd_s)); // see RULE2 see RULE3 see RULE5
  assign strobe_wr = !cs_n_s && (m6800 ? (rd_s && !wr_s) : (m8080 && !wr_s)); // see RULE2 see RULE3 see RULE6

  // Parallel strobe tracking and write latch
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rd_act_r <= 1'b0;
      wr_act_r <= 1'b0;
      wr_data_r <= MMHI_BYTE_RST;
      wr_dc_r <= 1'b0;
    end
    else
    begin
      rd_act_r <= strobe_rd;
      wr_act_r <= strobe_wr;
      // Keep the last value seen while the strobe is active
      if (strobe_wr)
      begin
        wr_data_r <= d_s;
        wr_dc_r <= dc_s; // see RULE8
      end
    end
  end

  // Parallel read: status direct, RAM data through one pipeline stage
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_data <= MMHI_BYTE_RST;
      rd_dc_r <= 1'b0;
      ram_pipe_r <= MMHI_BYTE_RST;
    end
    else
    begin
      if (strobe_rd && !rd_act_r)
      begin
        // Display read returns what the previous read fetched
        o_data <= dc_s ? ram_pipe_r : i_status; // see RULE4 see RULE8
        rd_dc_r <= dc_s;
      end
      if (rd_act_r && !strobe_rd && rd_dc_r)
      begin
        ram_pipe_r <= i_ram_rdata; // see RULE4
      end
    end
  end

  mmhi_spi_rx u_spi (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_en(m_spi),
    .i_three_wire(mode == MMHI_MODE_SPI3),
    .i_cs_n(cs_n_s), // see RULE11 see RULE12
    .i_scl_rise(scl_rise),
    .i_si(d_s[1]),
    .i_dc(dc_s),
    .o_valid(spi_v),
    .o_byte(spi_byte),
    .o_is_data(spi_dc)
  );

  assign tx_byte = dc_last_r ? i_ram_rdata : i_status; // see RULE24

  // I2C slave state machine
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      i2c_st_r <= MMHI_I_IDLE;
      i2c_sh_r <= MMHI_BYTE_RST;
      i2c_cnt_r <= MMHI_CNT_RST;
      i2c_ph_r <= MMHI_PH_ADDR;
      i2c_rw_r <= 1'b0;
      chain_r <= 1'b0;
      dc_last_r <= 1'b0;
      nack_r <= 1'b0;
      sda_rel_r <= 1'b1;
      i2c_wr_v_r <= 1'b0;
      i2c_rd_r <= 1'b0;
    end
    else
    begin
      i2c_wr_v_r <= 1'b0;
      i2c_rd_r <= 1'b0;
      if (!m_i2c)
      begin
        // Other modes leave the slave parked
        i2c_st_r <= MMHI_I_IDLE; // see RULE25
        sda_rel_r <= 1'b1;
      end
      else if (i2c_start)
      begin
        i2c_st_r <= MMHI_I_RX; // see RULE19
        i2c_cnt_r <= MMHI_CNT_RST;
        i2c_ph_r <= MMHI_PH_ADDR;
        sda_rel_r <= 1'b1;
      end
      else if (i2c_stop)
      begin
        i2c_st_r <= MMHI_I_IDLE; // see RULE19
        sda_rel_r <= 1'b1;
      end
      else
      begin
        unique case (i2c_st_r)
          MMHI_I_IDLE:
          begin
            sda_rel_r <= 1'b1;
          end
          MMHI_I_RX:
          begin
            if (scl_rise)
            begin
              i2c_sh_r <= {i2c_sh_r[6:0], d_s[1]};
              i2c_cnt_r <= i2c_cnt_r + 4'h1;
            end
            else if (scl_fall && i2c_cnt_r == MMHI_I2C_BITS)
            begin
              i2c_cnt_r <= MMHI_CNT_RST;
              i2c_st_r <= MMHI_I_ACK;
              sda_rel_r <= 1'b0; // see RULE20
              if (i2c_ph_r == MMHI_PH_ADDR)
              begin
                if (i2c_sh_r[7:1] == {MMHI_I2C_ADDR_HI, sa0_s}) // see RULE22
                begin
                  i2c_rw_r <= i2c_sh_r[0];
                  i2c_ph_r <= MMHI_PH_CTRL;
                end
                else
                begin
                  // Not ours: stay off the bus until the next START
                  i2c_st_r <= MMHI_I_IDLE;
                  sda_rel_r <= 1'b1;
                end
              end
              else if (i2c_ph_r == MMHI_PH_CTRL)
              begin
                chain_r <= i2c_sh_r[7]; // see RULE23
                dc_last_r <= i2c_sh_r[6];
                i2c_ph_r <= MMHI_PH_DATA;
              end
              else
              begin
                i2c_wr_v_r <= 1'b1; // see RULE17
                // Chain set: a control byte comes next; clear: data only
                i2c_ph_r <= chain_r ? MMHI_PH_CTRL : MMHI_PH_DATA; // see RULE23
              end
            end
          end
          MMHI_I_ACK:
          begin
            // Held low through the whole ninth clock; on its fall released for a write, or set to the first read bit for a read
            if (scl_fall)
            begin
              if (i2c_rw_r)
              begin
                i2c_st_r <= MMHI_I_TX; // see RULE17 see RULE24
                i2c_sh_r <= {tx_byte[6:0], 1'b0};
                sda_rel_r <= tx_byte[7];
                i2c_cnt_r <= 4'h1;
                i2c_rd_r <= dc_last_r;
              end
              else
              begin
                i2c_st_r <= MMHI_I_RX;
                sda_rel_r <= 1'b1;
              end
            end
          end
          MMHI_I_TX:
          begin
            if (scl_fall)
            begin
              if (i2c_cnt_r == MMHI_I2C_BITS)
              begin
                i2c_st_r <= MMHI_I_MACK;
                sda_rel_r <= 1'b1;
              end
              else
              begin
                sda_rel_r <= i2c_sh_r[7];
                i2c_sh_r <= {i2c_sh_r[6:0], 1'b0};
                i2c_cnt_r <= i2c_cnt_r + 4'h1;
              end
            end
          end
          MMHI_I_MACK:
          begin
            if (scl_rise)
            begin
              nack_r <= d_s[1];
            end
            else if (scl_fall)
            begin
              if (nack_r)
              begin
                // Last byte: leave SDA high for the master's STOP
                i2c_st_r <= MMHI_I_IDLE; // see RULE21
                sda_rel_r <= 1'b1;
              end
              else
              begin
                i2c_st_r <= MMHI_I_TX;
                i2c_sh_r <= {tx_byte[6:0], 1'b0};
                sda_rel_r <= tx_byte[7];
                i2c_cnt_r <= 4'h1;
                i2c_rd_r <= dc_last_r;
              end
            end
          end
        endcase
      end
    end
  end

  // Pin drive: parallel read bus, or the SDA open drain; one cycle behind
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_data_oe_n <= 8'hFF;
    end
    else if (m_par)
    begin
      o_data_oe_n <= strobe_rd ? 8'h00 : 8'hFF;
    end
    else if (m_i2c)
    begin
      o_data_oe_n <= {6'h3F, sda_rel_r, 1'b1};
    end
    else
    begin
      o_data_oe_n <= 8'hFF; // see RULE14 see RULE25
    end
  end

  // Byte hand-off to the command decoder or display RAM
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_wr_valid <= 1'b0;
      o_wr_is_data <= 1'b0;
      o_wr_byte <= MMHI_BYTE_RST;
      o_ram_rd <= 1'b0;
    end
    else
    begin
      o_wr_valid <= 1'b0;
      o_ram_rd <= (m_par && rd_act_r && !strobe_rd && rd_dc_r) || i2c_rd_r;
      if (m_par && wr_act_r && !strobe_wr)
      begin
        o_wr_valid <= 1'b1; // see RULE8
        o_wr_is_data <= wr_dc_r;
        o_wr_byte <= wr_data_r;
      end
      else if (spi_v)
      begin
        o_wr_valid <= 1'b1;
        o_wr_is_data <= spi_dc;
        o_wr_byte <= spi_byte;
      end
      else if (i2c_wr_v_r)
      begin
        o_wr_valid <= 1'b1;
        o_wr_is_data <= dc_last_r;
        o_wr_byte <= i2c_sh_r;
      end
    end
  end

  AST_SPI_NO_DRIVE: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see RULE14
    m_spi |=> (o_data_oe_n == 8'hFF))
    else $error("data pins driven in SPI mode");
  AST_PAR_WRITE: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see RULE8
    (m_par && wr_act_r && !strobe_wr) |=> (o_wr_valid && o_wr_is_data == $past(wr_dc_r)))
    else $error("parallel write not handed off");
  AST_PAR_READ_DRIVE: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see RULE5
    (m_par && strobe_rd) |=> (o_data_oe_n == 8'h00))
    else $error("read strobe did not drive the bus");
  AST_PAR_STATUS: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see RULE8
    (m_par && strobe_rd && !rd_act_r && !dc_s) |=> (o_data == $past(i_status)))
    else $error("status read returned wrong byte");
  AST_I2C_ACK_LOW: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see RULE20
    (m_i2c && i2c_st_r == MMHI_I_ACK && !i2c_start && !i2c_stop && !scl_fall) |=> (o_data_oe_n[1] == 1'b0))
    else $error("acknowledge not driven low");
  AST_I2C_FOREIGN: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see RULE22
    (m_i2c && i2c_st_r == MMHI_I_RX && i2c_ph_r == MMHI_PH_ADDR && scl_fall && !i2c_start && !i2c_stop
      && i2c_cnt_r == MMHI_I2C_BITS && i2c_sh_r[7:1] != {MMHI_I2C_ADDR_HI, sa0_s}) |=> (i2c_st_r == MMHI_I_IDLE))
    else $error("foreign address acknowledged");
  AST_I2C_NACK: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see RULE21
    (m_i2c && i2c_st_r == MMHI_I_MACK && scl_fall && nack_r && !i2c_start && !i2c_stop)
    |=> (i2c_st_r == MMHI_I_IDLE) ##1 o_data_oe_n[1])
    else $error("SDA not released after master nack");
  AST_MODE_GATE: assert property (@(posedge i_sys_clk) disable iff (i_rst) // see RULE1
    (mode == MMHI_MODE_I2C) |-> !spi_v)
    else $error("SPI byte delivered in I2C mode");
endmodule
`default_nettype wire

//--- mmhi_host_model.sv
// Host model driving the parallel, SPI and I2C pins of the port
`timescale 1ns/1ps
`default_nettype none
module mmhi_host_model
(
  input wire logic i_clk,
  input wire logic i_sda,
  input wire logic [7:0] i_rd_data,
  input wire logic [7:0] i_oe_n,
  output logic o_cs_n,
  output logic o_dc,
  output logic o_rd_e,
  output logic o_wr_rw,
  output logic [7:0] o_data
);
  logic m6800; // 1: 6800 strobes, 0: 8080 strobes
  logic [7:0] rx_byte; // Last eight data-line bits seen at the end of clock high
  // Idle pins at time zero
  initial
  begin
    m6800 = 1'b0;
    o_cs_n = 1'b1;
    o_dc = 1'b0;
    o_rd_e = 1'b1;
    o_wr_rw = 1'b1;
    o_data = 8'h03;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // One parallel access; 6-cycle strobe leaves margin over the 4-cycle minimum
  task automatic pacc(input logic rd, input logic dc, input logic [7:0] d,
                      output logic [7:0] q, output logic [7:0] qoe);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_dc <= dc;
    o_data <= rd ? ~o_data : d; // Released bus never shows the old byte
    o_wr_rw <= m6800 ? rd : 1'b1;
    o_rd_e <= ~m6800;
    tick(1);
    if (m6800)
      o_rd_e <= 1'b1;
    else if (rd)
      o_rd_e <= 1'b0;
    else
      o_wr_rw <= 1'b0;
    tick(6);
    q = i_rd_data;
    qoe = i_oe_n;
    o_rd_e <= ~m6800;
    o_wr_rw <= 1'b1;
    tick(6);
    o_cs_n <= 1'b1;
    tick(2);
  endtask
  // One serial bit at a 200 ns clock period
  task automatic sbit(input logic b);
    o_data[1] <= b;
    tick(4);
    o_data[0] <= 1'b1;
    tick(4);
    // Sampled late in clock high, after the port's one-cycle drive lag has settled
    rx_byte = {rx_byte[6:0], i_sda};
    o_data[0] <= 1'b0;
  endtask
  // SPI frame of n bits, MSB first; clock stands low outside the frame
  task automatic spi(input int n, input logic [8:0] v, input logic dc);
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_dc <= dc;
    o_data[0] <= 1'b0;
    tick(4);
    for (int i = n - 1; i >= 0; i--)
      sbit(v[i]);
    tick(4);
    o_cs_n <= 1'b1;
    o_data[1] <= ~o_data[1]; // Deselected line toggles its level
    tick(8);
  endtask
  // START from an idle-high bus
  task automatic i2c_start();
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_data[1:0] <= 2'h3;
    tick(4);
    o_data[1] <= 1'b0;
    tick(4);
    o_data[0] <= 1'b0;
    tick(4);
  endtask
  task automatic i2c_stop();
    o_data[1] <= 1'b0;
    tick(4);
    o_data[0] <= 1'b1;
    tick(4);
    o_data[1] <= 1'b1;
    tick(8);
  endtask
  // Byte out, then release data; ack is high if the line is high at either of two samples in clock high
  task automatic i2c_byte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--)
      sbit(v[i]);
    o_data[1] <= 1'b1;
    tick(4);
    o_data[0] <= 1'b1;
    tick(1);
    ack = i_sda;
    tick(3);
    ack = ack | i_sda;
    o_data[0] <= 1'b0;
    tick(4);
  endtask
endmodule
`default_nettype wire

//--- test_mmhi_top.sv
// Self-checking bench of the multi-mode host port
`timescale 1ns/1ps
`default_nettype none
module test_mmhi_top
  import mmhi_pkg::*;
();
  logic sys_clk, rst, s0, s1, s2, lsb, cs_n, dc, rd_e, wr_rw, wr_valid, wr_is_data, ram_rd;
  logic [7:0] h_data, o_data, oe_n, wr_byte, q, qoe;
  logic [7:0] status_byte = 8'hC3;
  logic [7:0] ram_byte = 8'h5A;
  logic [5:0] a;
  wire logic [7:0] pin_data;
  logic [8:0] wr_q[$]; // Bytes for the core, flag on top
  int ram_rd_cnt = 0;
  int error_cnt = 0;
  int num_checks = 0;
  // Open-drain data line: pulled low by the port or the host
  assign pin_data = {h_data[7:2], h_data[1] & oe_n[1], h_data[0]};
  mmhi_top i_dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_interface_strap_zero(s0),
    .i_interface_strap_one(s1), .i_interface_strap_two(s2), .i_address_lsb_strap(lsb),
    .i_cs_n(cs_n), .i_data_command_select(dc), .i_rd_e(rd_e), .i_wr_rw(wr_rw),
    .i_data(pin_data), .i_status(status_byte), .i_ram_rdata(ram_byte), .o_data(o_data),
    .o_data_oe_n(oe_n), .o_wr_valid(wr_valid), .o_wr_is_data(wr_is_data),
    .o_wr_byte(wr_byte), .o_ram_rd(ram_rd));
  mmhi_host_model i_host (.i_clk(sys_clk), .i_sda(pin_data[1]), .i_rd_data(o_data),
    .i_oe_n(oe_n), .o_cs_n(cs_n), .o_dc(dc), .o_rd_e(rd_e), .o_wr_rw(wr_rw), .o_data(h_data));
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Collect write pulses and RAM-consume pulses
  always @(posedge sys_clk)
  begin
    if (wr_valid === 1'b1)
      wr_q.push_back({wr_is_data, wr_byte});
    if (ram_rd === 1'b1)
      ram_rd_cnt++;
  end
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Oldest delivered byte; unknown when none came
  task automatic chk_wr(input logic [8:0] exp);
    chk("write", exp, (wr_q.size() > 0) ? wr_q.pop_front() : {9{1'bx}});
  endtask
  // Straps change only under reset, held 16 cycles
  task automatic start(input logic [2:0] mode);
    @(posedge sys_clk);
    rst <= 1'b1;
    {s0, s1, s2} <= mode;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    wr_q.delete();
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, far beyond the few thousand cycles needed
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    rst = 1'b1;
    {s0, s1, s2} = 3'h0;
    lsb = 1'b0;
    start(MMHI_MODE_8080);
    i_host.pacc(1'b0, 1'b0, 8'hAE, q, qoe);
    chk_wr({1'b0, 8'hAE});
    i_host.pacc(1'b0, 1'b1, 8'h5C, q, qoe);
    chk_wr({1'b1, 8'h5C});
    i_host.pacc(1'b1, 1'b0, 8'h00, q, qoe);
    chk("status", {1'b0, status_byte}, {1'b0, q});
    chk("read enable", 9'h000, {1'b0, qoe});
    i_host.pacc(1'b1, 1'b1, 8'h00, q, qoe);
    ram_byte <= 8'h66; // Address moved on after the consume pulse
    chk("dummy read", 9'h000, {1'b0, q});
    i_host.pacc(1'b1, 1'b1, 8'h00, q, qoe);
    chk("ram read", 9'h05A, {1'b0, q});
    chk("ram consume", 9'h002, 9'(ram_rd_cnt));
    start(MMHI_MODE_6800);
    i_host.m6800 = 1'b1;
    i_host.pacc(1'b0, 1'b0, 8'h81, q, qoe);
    chk_wr({1'b0, 8'h81});
    i_host.pacc(1'b1, 1'b0, 8'h00, q, qoe);
    chk("status 6800", {1'b0, status_byte}, {1'b0, q});
    start(3'h7);
    i_host.pacc(1'b0, 1'b1, 8'h11, q, qoe);
    chk("no mode", 9'h000, 9'(wr_q.size()));
    start(MMHI_MODE_SPI4);
    i_host.spi(8, 9'h0A5, 1'b1);
    chk_wr({1'b1, 8'hA5});
    i_host.spi(8, 9'h03C, 1'b0);
    chk_wr({1'b0, 8'h3C});
    i_host.spi(5, 9'h01F, 1'b1);
    i_host.spi(8, 9'h081, 1'b0);
    chk_wr({1'b0, 8'h81});
    chk("partial frame", 9'h000, 9'(wr_q.size()));
    i_host.m6800 = 1'b0;
    i_host.pacc(1'b1, 1'b1, 8'h00, q, qoe);
    chk("spi no read", 9'h0FF, {1'b0, qoe});
    start(MMHI_MODE_SPI3);
    i_host.spi(9, 9'h1C3, 1'b0);
    chk_wr({1'b1, 8'hC3});
    i_host.spi(9, 9'h07E, 1'b1);
    chk_wr({1'b0, 8'h7E});
    start(MMHI_MODE_I2C);
    i_host.i2c_start();
    i_host.i2c_byte(8'h78, a[0]);
    i_host.i2c_byte(8'h80, a[1]);
    i_host.i2c_byte(8'hAE, a[2]);
    i_host.i2c_byte(8'h40, a[3]);
    i_host.i2c_byte(8'h12, a[4]);
    i_host.i2c_byte(8'h34, a[5]);
    i_host.i2c_stop();
    chk("acks", 9'h000, {3'h0, a});
    chk_wr({1'b0, 8'hAE});
    chk_wr({1'b1, 8'h12});
    chk_wr({1'b1, 8'h34});
    i_host.i2c_start();
    i_host.i2c_byte(8'h7A, a[0]);
    i_host.i2c_stop();
    chk("foreign address", 9'h001, {8'h00, a[0]});
    chk("foreign writes", 9'h000, 9'(wr_q.size()));
    // Read with RAM as source: last control byte selected data
    i_host.i2c_start();
    i_host.i2c_byte(8'h79, a[0]);
    i_host.i2c_byte(8'hFF, a[1]);
    i_host.i2c_stop();
    chk("i2c ram read", 9'h066, {1'b0, i_host.rx_byte});
    chk("read acks", 9'h002, {7'h00, a[1:0]});
    // Address strap high: the other address answers, status is read back
    lsb <= 1'b1;
    start(MMHI_MODE_I2C);
    i_host.i2c_start();
    i_host.i2c_byte(8'h7A, a[0]);
    i_host.i2c_byte(8'h00, a[1]);
    i_host.i2c_byte(8'h5E, a[2]);
    i_host.i2c_stop();
    chk_wr({1'b0, 8'h5E});
    i_host.i2c_start();
    i_host.i2c_byte(8'h7B, a[3]);
    i_host.i2c_byte(8'hFF, a[4]);
    i_host.i2c_stop();
    chk("i2c status", {1'b0, status_byte}, {1'b0, i_host.rx_byte});
    chk("strap acks", 9'h010, {4'h0, a[4:0]});
    chk("i2c consume", 9'h003, 9'(ram_rd_cnt));
    print_verdict();
  end
endmodule
`default_nettype wire
